// [rtl/rsc_pkg.sv]
// Package: constants and status codes for the ranging service block
// What this block does
// - Hold timer expiring before any data request raises the expiry notice.
// - Parameterless notice also means default preamble indices are back.
// - Enable starts a 24-bit symbol hold timer, then confirms.
// - Sounding requests are accepted and confirmed only when no earlier confirm is waiting.
// - With sounding present and no results, a request starts a measurement if no run is open and the PHY is idle.
// - With results available and the PHY idle, return success and the sounding point list.
// - Sounding request with no results present returns no-data status.
// - No sounding hardware: sounding request returns feature-absent status.
// - Each point holds a signed 16 ps time and a signed strength value.
// - Each calibration request taken while no confirm waits is answered with status and offsets.
// - Two unsigned 32-bit path delays, LSB 1/128 chip at 499.2 MHz.
// - Calibration supported, with offsets present and the PHY idle, returns success status.
// - Calibration request with no offsets present returns no-data status.
// - No autonomous self-calibration returns the host-computation code.
// - No sounding hardware: calibration request returns feature-absent.
package rsc_pkg;
  localparam int HOLD_W = 24;
  localparam logic [HOLD_W-1:0] HOLD_MAX = 24'hffffff;
  localparam int OFFSET_W = 32;
  localparam int TIME_W = 16;
  localparam int STRENGTH_W = 16;
  localparam int POINT_IDX_W = 4;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYMBOL_NS = 1000;
  localparam int SYMBOL_CYCLES =
    (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYM_CNT_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 24'h000000;
  localparam logic [OFFSET_W-1:0] OFFSET_RESET = 32'h00000000;

  // Sounding confirmation status
  typedef enum logic [1:0] {
    RSC_SND_SUCCESS,
    RSC_SND_NO_DATA,
    RSC_SND_FEATURE_ABSENT
  } rsc_snd_status_e;

  // Calibration confirmation status
  typedef enum logic [1:0] {
    RSC_CAL_SUCCESS,
    RSC_CAL_NO_DATA,
    RSC_CAL_HOST_COMPUTATION_REQUIRED,
    RSC_CAL_FEATURE_ABSENT
  } rsc_cal_status_e;
endpackage

// [rtl/rsc_hold_timer.sv]
// Dynamic-preamble hold timer counted in symbols
`timescale 1ns/10ps
module rsc_hold_timer #(
  parameter int SYM_CYCLES = rsc_pkg::SYMBOL_CYCLES
) (
  input wire logic clk, // 20 MHz clock
  input wire logic rst, // Async reset, high
  input wire logic start, // Load pulse
  input wire logic cancel, // Stop without expiry
  input wire logic [rsc_pkg::HOLD_W-1:0] symbols, // Hold length
  output logic running, // Timer active
  output logic expired // One-cycle expiry pulse
);
  localparam int CW = rsc_pkg::SYM_CNT_W;
  logic [rsc_pkg::HOLD_W-1:0] remain, next_remain;
  logic [rsc_pkg::SYM_CNT_W-1:0] tick, next_tick;
  logic next_running, next_expired;

  // Symbol prescaler then symbol down-counter
  always_comb begin
    next_remain = remain;
    next_tick = tick;
    next_running = running;
    next_expired = 1'b0;
    if (start) begin
      next_remain = symbols;
      next_tick = '0;
      next_running = 1'b1;
    end else if (cancel) begin
      next_running = 1'b0;
    end else if (running) begin
      if (tick == CW'(SYM_CYCLES - 1)) begin
        next_tick = '0;
        // Expire on the last symbol; a zero hold still lasts one symbol
        if (remain[rsc_pkg::HOLD_W-1:1] == '0) begin
          next_running = 1'b0;
          next_expired = 1'b1;
        end else begin
          next_remain = remain - 1'b1;
        end
      end else begin
        next_tick = tick + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain <= rsc_pkg::HOLD_RESET;
      tick <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      remain <= next_remain;
      tick <= next_tick;
      running <= next_running;
      expired <= next_expired;
    end
  end
endmodule // rsc_hold_timer

// [rtl/rsc_service.sv]
// Ranging, sounding and calibration management responder
`timescale 1ns/10ps
module rsc_service #(
  parameter int SYM_CYCLES = rsc_pkg::SYMBOL_CYCLES,
  parameter int MAX_POINTS = 16
) (
  input wire logic clk, // 20 MHz clock
  input wire logic rst, // Async reset, high
  // Dynamic preamble side
  input wire logic dps_req, // Enable/cancel request pulse
  input wire logic dps_enable, // 1 enable, 0 cancel
  input wire logic [rsc_pkg::HOLD_W-1:0] preamble_hold_symbols, // Hold
  input wire logic data_req, // Data request pulse
  output logic dps_cnf, // Confirm pulse
  output logic dps_expiry_ind, // Expiry notice pulse
  output logic preamble_restore, // Restore default indices pulse
  output logic dps_active, // Dynamic preamble in use
  // Sounding request/confirm
  input wire logic snd_req, // Sounding request pulse
  output logic snd_cnf_valid, // Confirm held until taken
  input wire logic snd_cnf_ready, // Higher layer accepts
  output logic [1:0] snd_status, // Sounding status
  output logic [rsc_pkg::POINT_IDX_W:0] snd_point_count, // Points
  input wire logic [rsc_pkg::POINT_IDX_W-1:0] snd_point_sel, // Read index
  output logic signed [rsc_pkg::TIME_W-1:0] sounding_point_time, // Time
  output logic signed [rsc_pkg::STRENGTH_W-1:0] sounding_point_strength,
  // Calibration request/confirm
  input wire logic cal_req, // Calibration request pulse
  output logic cal_cnf_valid, // Confirm held until taken
  input wire logic cal_cnf_ready, // Higher layer accepts
  output logic [1:0] cal_status, // Calibration status
  output logic [rsc_pkg::OFFSET_W-1:0] tx_path_delay_offset, // Tx delay
  output logic [rsc_pkg::OFFSET_W-1:0] rx_path_delay_offset, // Rx delay
  // PHY side
  input wire logic phy_sounding_cap, // Sounding hardware present
  input wire logic phy_self_cal_cap, // Autonomous calibration
  output logic phy_snd_start, // Start measurement pulse
  input wire logic phy_busy, // Measurement in progress
  input wire logic phy_pt_valid, // Result point strobe
  input wire logic signed [rsc_pkg::TIME_W-1:0] phy_pt_time, // Point time
  input wire logic signed [rsc_pkg::STRENGTH_W-1:0] phy_pt_strength,
  input wire logic phy_pt_last, // Final point of run
  input wire logic phy_cal_valid, // Offsets strobe
  input wire logic [rsc_pkg::OFFSET_W-1:0] phy_tx_offset, // Tx offset
  input wire logic [rsc_pkg::OFFSET_W-1:0] phy_rx_offset // Rx offset
);
  // Point index width; the store holds at most 2**PW points
  localparam int PW = rsc_pkg::POINT_IDX_W;

  logic timer_running, timer_expired;
  logic next_dps_cnf, next_dps_expiry_ind, next_dps_active;
  logic next_preamble_restore;

  // Hold timer; a data request ends the hold with no expiry
  // Start wins over a data request; a cancel ends the hold silently
  rsc_hold_timer #(
    .SYM_CYCLES(SYM_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(dps_req && dps_enable),
    .cancel(data_req || (dps_req && !dps_enable)),
    .symbols(preamble_hold_symbols),
    .running(timer_running),
    .expired(timer_expired)
  );

  // Dynamic preamble confirm and expiry notice
  always_comb begin
    next_dps_cnf = dps_req;
    // A data request in the expiry cycle still suppresses the notice
    next_dps_expiry_ind = timer_expired && !data_req;
    next_preamble_restore = timer_expired && !data_req;
    next_dps_active = dps_active;
    if (dps_req) begin
      next_dps_active = dps_enable;
    end else if (timer_expired || data_req) begin
      next_dps_active = 1'b0;
    end
  end

  // Confirm and notices are one-cycle pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dps_cnf <= 1'b0;
      dps_expiry_ind <= 1'b0;
      preamble_restore <= 1'b0;
      dps_active <= 1'b0;
    end else begin
      dps_cnf <= next_dps_cnf;
      dps_expiry_ind <= next_dps_expiry_ind;
      preamble_restore <= next_preamble_restore;
      dps_active <= next_dps_active;
    end
  end

  // Sounding result store; array filled by PHY point strobes
  logic signed [rsc_pkg::TIME_W-1:0] pt_time [MAX_POINTS];
  logic signed [rsc_pkg::STRENGTH_W-1:0] pt_strength [MAX_POINTS];
  logic [PW:0] wr_count, next_wr_count;
  logic results_ok, next_results_ok;
  logic [PW:0] res_count, next_res_count;
  // Run handed to the PHY whose last point has not come back yet
  logic run_open, next_run_open;

  // True while the point store still has a free slot
  function automatic logic has_room(input logic [PW:0] cnt);
    return cnt < (PW+1)'(MAX_POINTS);
  endfunction

  // Point storage, one array write per strobe
  // No reset on the store: the counts mark what is valid
  always_ff @(posedge clk) begin
    if (phy_pt_valid && has_room(wr_count)) begin
      pt_time[wr_count[PW-1:0]] <= phy_pt_time;
      pt_strength[wr_count[PW-1:0]] <= phy_pt_strength;
    end
  end

  // Result bookkeeping; results invalid while a run is filling
  always_comb begin
    next_wr_count = wr_count;
    next_results_ok = results_ok;
    next_res_count = res_count;
    next_run_open = run_open;
    if (phy_snd_start) begin
      next_wr_count = '0;
      next_results_ok = 1'b0;
      next_run_open = 1'b1;
    end else if (phy_pt_valid && has_room(wr_count)) begin
      next_wr_count = wr_count + 1'b1;
    end
    // Final point sets the results; set wins over a same-cycle start
    if (phy_pt_valid && phy_pt_last) begin
      next_results_ok = 1'b1;
      next_run_open = 1'b0;
      if (has_room(wr_count)) begin
        next_res_count = wr_count + 1'b1;
      end else begin
        next_res_count = wr_count;
      end
    end
  end

  // Store bookkeeping registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_count <= '0;
      results_ok <= 1'b0;
      res_count <= '0;
      run_open <= 1'b0;
    end else begin
      wr_count <= next_wr_count;
      results_ok <= next_results_ok;
      res_count <= next_res_count;
      run_open <= next_run_open;
    end
  end

  // Sounding request handling
  logic next_snd_cnf_valid, next_phy_snd_start;
  logic [1:0] next_snd_status;
  logic [PW:0] next_snd_point_count;

  // Confirm registers stand until the higher layer takes them
  always_comb begin
    next_snd_cnf_valid = snd_cnf_valid;
    next_snd_status = snd_status;
    next_snd_point_count = snd_point_count;
    next_phy_snd_start = 1'b0;
    if (snd_cnf_valid) begin
      // Held stable; new requests ignored until taken
      if (snd_cnf_ready) begin
        next_snd_cnf_valid = 1'b0;
      end
    end else if (snd_req) begin
      next_snd_cnf_valid = 1'b1;
      next_snd_point_count = '0;
      if (!phy_sounding_cap) begin
        next_snd_status = 2'(rsc_pkg::RSC_SND_FEATURE_ABSENT);
      end else if (results_ok && !phy_busy) begin
        next_snd_status = 2'(rsc_pkg::RSC_SND_SUCCESS);
        // Count is that of the finished run, capped at the store size
        next_snd_point_count = res_count;
      end else begin
        next_snd_status = 2'(rsc_pkg::RSC_SND_NO_DATA);
        // Start a run only if none is going; a PHY that never sends
        // its last point blocks further runs until reset
        next_phy_snd_start = !phy_busy && !run_open;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snd_cnf_valid <= 1'b0;
      snd_status <= 2'h0;
      snd_point_count <= '0;
      phy_snd_start <= 1'b0;
    end else begin
      snd_cnf_valid <= next_snd_cnf_valid;
      snd_status <= next_snd_status;
      snd_point_count <= next_snd_point_count;
      phy_snd_start <= next_phy_snd_start;
    end
  end

  // Point read port; a new run is only started from an empty confirm
  // An index past the count reads zero, never stale points
  logic signed [rsc_pkg::TIME_W-1:0] next_pt_time;
  logic signed [rsc_pkg::STRENGTH_W-1:0] next_pt_strength;

  always_comb begin
    next_pt_time = '0;
    next_pt_strength = '0;
    if ((PW+1)'(snd_point_sel) < snd_point_count) begin
      next_pt_time = pt_time[snd_point_sel];
      next_pt_strength = pt_strength[snd_point_sel];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sounding_point_time <= '0;
      sounding_point_strength <= '0;
    end else begin
      sounding_point_time <= next_pt_time;
      sounding_point_strength <= next_pt_strength;
    end
  end

  // Calibration offsets captured from PHY
  // Offsets kept from the last PHY strobe until reset; no ageing
  logic cal_ok, next_cal_ok;
  logic [rsc_pkg::OFFSET_W-1:0] cal_tx, cal_rx, next_cal_tx, next_cal_rx;
  logic next_cal_cnf_valid;
  logic [1:0] next_cal_status;
  logic [rsc_pkg::OFFSET_W-1:0] next_tx_off, next_rx_off;

  always_comb begin
    next_cal_ok = cal_ok;
    next_cal_tx = cal_tx;
    next_cal_rx = cal_rx;
    if (phy_cal_valid) begin
      next_cal_ok = 1'b1;
      next_cal_tx = phy_tx_offset;
      next_cal_rx = phy_rx_offset;
    end
  end

  // Calibration request; priority absent, host, no-data, success
  always_comb begin
    next_cal_cnf_valid = cal_cnf_valid;
    next_cal_status = cal_status;
    next_tx_off = tx_path_delay_offset;
    next_rx_off = rx_path_delay_offset;
    if (cal_cnf_valid) begin
      if (cal_cnf_ready) begin
        next_cal_cnf_valid = 1'b0;
      end
    end else if (cal_req) begin
      next_cal_cnf_valid = 1'b1;
      // Offsets read zero unless the answer is a success
      next_tx_off = rsc_pkg::OFFSET_RESET;
      next_rx_off = rsc_pkg::OFFSET_RESET;
      if (!phy_sounding_cap) begin
        next_cal_status = 2'(rsc_pkg::RSC_CAL_FEATURE_ABSENT);
      end else if (!phy_self_cal_cap) begin
        // Host finishes with sounding requests
        next_cal_status =
          2'(rsc_pkg::RSC_CAL_HOST_COMPUTATION_REQUIRED);
      end else if (!cal_ok || phy_busy) begin
        next_cal_status = 2'(rsc_pkg::RSC_CAL_NO_DATA);
      end else begin
        next_cal_status = 2'(rsc_pkg::RSC_CAL_SUCCESS);
        next_tx_off = cal_tx;
        next_rx_off = cal_rx;
      end
    end
  end

  // Capture and answer registers share one reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_ok <= 1'b0;
      cal_tx <= rsc_pkg::OFFSET_RESET;
      cal_rx <= rsc_pkg::OFFSET_RESET;
      cal_cnf_valid <= 1'b0;
      cal_status <= 2'h0;
      tx_path_delay_offset <= rsc_pkg::OFFSET_RESET;
      rx_path_delay_offset <= rsc_pkg::OFFSET_RESET;
    end else begin
      cal_ok <= next_cal_ok;
      cal_tx <= next_cal_tx;
      cal_rx <= next_cal_rx;
      cal_cnf_valid <= next_cal_cnf_valid;
      cal_status <= next_cal_status;
      tx_path_delay_offset <= next_tx_off;
      rx_path_delay_offset <= next_rx_off;
    end
  end
endmodule // rsc_service

// [tb/rsc_service_assertions.sv]
// Port-level checker for the ranging service responder
`timescale 1ns/10ps
module rsc_service_assertions (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, high
  input wire logic dps_req, // DPS request
  input wire logic dps_cnf, // DPS confirm
  input wire logic dps_expiry_ind, // Expiry notice
  input wire logic preamble_restore, // Restore pulse
  input wire logic snd_req, // Sounding request
  input wire logic snd_cnf_valid, // Sounding confirm
  input wire logic snd_cnf_ready, // Sounding accept
  input wire logic [1:0] snd_status, // Sounding status
  input wire logic [4:0] snd_point_count, // Point count
  input wire logic cal_req, // Calibration request
  input wire logic cal_cnf_valid, // Calibration confirm
  input wire logic cal_cnf_ready, // Calibration accept
  input wire logic [1:0] cal_status, // Calibration status
  input wire logic [31:0] tx_path_delay_offset, // Tx delay
  input wire logic [31:0] rx_path_delay_offset, // Rx delay
  input wire logic phy_sounding_cap, // Sounding present
  input wire logic phy_self_cal_cap, // Self calibration
  input wire logic phy_snd_start // Run start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Requests that are taken, refused ones left out
  sequence s_snd_take; snd_req && !snd_cnf_valid; endsequence
  sequence s_cal_take; cal_req && !cal_cnf_valid; endsequence
  property p_dps_cnf; dps_req |=> dps_cnf; endproperty
  a_dps_cnf: assert property (p_dps_cnf)
    else $error("dps confirm missing");
  property p_restore; dps_expiry_ind == preamble_restore; endproperty
  a_restore: assert property (p_restore)
    else $error("restore not with notice");
  property p_snd_cnf; s_snd_take |=> $rose(snd_cnf_valid); endproperty
  a_snd_cnf: assert property (p_snd_cnf)
    else $error("sounding confirm missing");
  property p_snd_hold;
    snd_cnf_valid && !snd_cnf_ready |=> snd_cnf_valid &&
      $stable(snd_status) && $stable(snd_point_count);
  endproperty
  a_snd_hold: assert property (p_snd_hold)
    else $error("sounding answer moved");
  property p_snd_drop; snd_cnf_valid && snd_cnf_ready |=> !snd_cnf_valid;
  endproperty
  a_snd_drop: assert property (p_snd_drop)
    else $error("sounding confirm stuck");
  property p_snd_absent;
    s_snd_take ##0 !phy_sounding_cap |=> snd_status == 2'h2;
  endproperty
  a_snd_absent: assert property (p_snd_absent)
    else $error("sounding absent code wrong");
  property p_snd_start; phy_snd_start |-> $rose(snd_cnf_valid); endproperty
  a_snd_start: assert property (p_snd_start)
    else $error("run start without request");
  property p_cal_cnf; s_cal_take |=> $rose(cal_cnf_valid); endproperty
  a_cal_cnf: assert property (p_cal_cnf)
    else $error("calibration confirm missing");
  property p_cal_absent;
    s_cal_take ##0 !phy_sounding_cap |=> cal_status == 2'h3;
  endproperty
  a_cal_absent: assert property (p_cal_absent)
    else $error("calibration absent code wrong");
  property p_cal_host;
    s_cal_take ##0 phy_sounding_cap && !phy_self_cal_cap
      |=> cal_status == 2'h2;
  endproperty
  a_cal_host: assert property (p_cal_host)
    else $error("host computation code wrong");
  property p_cal_hold;
    cal_cnf_valid && !cal_cnf_ready |=> cal_cnf_valid && $stable(cal_status)
      && $stable(tx_path_delay_offset) && $stable(rx_path_delay_offset);
  endproperty
  a_cal_hold: assert property (p_cal_hold)
    else $error("calibration answer moved");
endmodule // rsc_service_assertions

bind rsc_service rsc_service_assertions u_chk (.clk, .rst, .dps_req,
  .dps_cnf, .dps_expiry_ind, .preamble_restore, .snd_req, .snd_cnf_valid,
  .snd_cnf_ready, .snd_status, .snd_point_count, .cal_req, .cal_cnf_valid,
  .cal_cnf_ready, .cal_status, .tx_path_delay_offset, .rx_path_delay_offset,
  .phy_sounding_cap, .phy_self_cal_cap, .phy_snd_start);

// [tb/rsc_phy_model.sv]
// Behavioural radio model supplying sounding points and path offsets
`timescale 1ns/10ps
module rsc_phy_model #(
  parameter int NPTS = 3, // Points per run
  parameter int BUSY = 20, // Measuring cycles
  parameter logic [31:0] TXO = 32'h00000001, // Tx offset
  parameter logic [31:0] RXO = 32'h00000002 // Rx offset
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, high
  input wire logic phy_snd_start, // Run request
  input wire logic cal_go, // Offsets ready trigger
  output logic phy_busy, // Measuring
  output logic phy_pt_valid, // Point strobe
  output logic signed [15:0] phy_pt_time, // Point time
  output logic signed [15:0] phy_pt_strength, // Point strength
  output logic phy_pt_last, // Last point
  output logic phy_cal_valid, // Offsets strobe
  output logic [31:0] phy_tx_offset, // Tx offset
  output logic [31:0] phy_rx_offset // Rx offset
);
  int cnt;
  logic [15:0] k;
  // Run counter; a fresh start restarts the run mid-measurement
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      phy_cal_valid <= 1'b0;
    end else begin
      phy_cal_valid <= cal_go;
      if (phy_snd_start) cnt <= 1;
      else if (cnt == BUSY + NPTS) cnt <= 0;
      else if (cnt != 0) cnt <= cnt + 1;
    end
  end
  // Idle data lines show the inverse, so stale values never look valid
  assign k = 16'(cnt - BUSY - 1);
  assign phy_busy = (cnt != 0) && (cnt <= BUSY);
  assign phy_pt_valid = (cnt > BUSY);
  assign phy_pt_last = (cnt == BUSY + NPTS);
  assign phy_pt_time = phy_pt_valid ? 16'hfff0 - k : 16'h000f + k;
  assign phy_pt_strength = phy_pt_valid ? 16'h0100 + k : 16'hfeff - k;
  assign phy_tx_offset = phy_cal_valid ? TXO : ~TXO;
  assign phy_rx_offset = phy_cal_valid ? RXO : ~RXO;
endmodule // rsc_phy_model

// [tb/tb_top.sv]
// Self-checking bench for the ranging service responder
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] TXO = 32'hffffffff;
  localparam logic [31:0] RXO = 32'h00000001;
  logic clk, rst, dps_req, dps_enable, data_req, dps_cnf, dps_expiry_ind;
  logic preamble_restore, dps_active, snd_req, snd_cnf_valid, snd_cnf_ready;
  logic cal_req, cal_cnf_valid, cal_cnf_ready, phy_sounding_cap, cal_go;
  logic phy_self_cal_cap, phy_snd_start, phy_busy, phy_pt_valid, phy_pt_last;
  logic phy_cal_valid;
  logic [1:0] snd_status, cal_status;
  logic [4:0] snd_point_count;
  logic [3:0] snd_point_sel;
  logic [23:0] preamble_hold_symbols;
  logic signed [15:0] sounding_point_time, sounding_point_strength;
  logic signed [15:0] phy_pt_time, phy_pt_strength;
  logic [31:0] tx_path_delay_offset, rx_path_delay_offset;
  logic [31:0] phy_tx_offset, phy_rx_offset;
  int failures, num_checks, starts, exps;
  rsc_service #(.SYM_CYCLES(2)) uut (
    .clk(clk), .rst(rst), .dps_req(dps_req), .dps_enable(dps_enable),
    .preamble_hold_symbols(preamble_hold_symbols), .data_req(data_req),
    .dps_cnf(dps_cnf), .dps_expiry_ind(dps_expiry_ind),
    .preamble_restore(preamble_restore), .dps_active(dps_active),
    .snd_req(snd_req), .snd_cnf_valid(snd_cnf_valid),
    .snd_cnf_ready(snd_cnf_ready), .snd_status(snd_status),
    .snd_point_count(snd_point_count), .snd_point_sel(snd_point_sel),
    .sounding_point_time(sounding_point_time),
    .sounding_point_strength(sounding_point_strength),
    .cal_req(cal_req), .cal_cnf_valid(cal_cnf_valid),
    .cal_cnf_ready(cal_cnf_ready), .cal_status(cal_status),
    .tx_path_delay_offset(tx_path_delay_offset),
    .rx_path_delay_offset(rx_path_delay_offset),
    .phy_sounding_cap(phy_sounding_cap),
    .phy_self_cal_cap(phy_self_cal_cap), .phy_snd_start(phy_snd_start),
    .phy_busy(phy_busy), .phy_pt_valid(phy_pt_valid),
    .phy_pt_time(phy_pt_time), .phy_pt_strength(phy_pt_strength),
    .phy_pt_last(phy_pt_last), .phy_cal_valid(phy_cal_valid),
    .phy_tx_offset(phy_tx_offset), .phy_rx_offset(phy_rx_offset)
  );
  rsc_phy_model #(.TXO(TXO), .RXO(RXO)) u_phy (
    .clk(clk), .rst(rst), .phy_snd_start(phy_snd_start), .cal_go(cal_go),
    .phy_busy(phy_busy), .phy_pt_valid(phy_pt_valid),
    .phy_pt_time(phy_pt_time), .phy_pt_strength(phy_pt_strength),
    .phy_pt_last(phy_pt_last), .phy_cal_valid(phy_cal_valid),
    .phy_tx_offset(phy_tx_offset), .phy_rx_offset(phy_rx_offset)
  );
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Event counters for run starts and expiry notices
  always @(posedge clk) begin
    if (phy_snd_start) starts++;
    if (dps_expiry_ind) exps++;
  end
  task automatic chk(input logic [31:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Sounding exchange; a refused request lands while the answer waits
  task automatic snd(input logic [1:0] st, input int np);
    @(negedge clk) snd_req = 1;
    @(negedge clk) snd_req = 0;
    chk(snd_cnf_valid, 1, "snd valid");
    chk(snd_status, st, "snd status");
    if (np >= 0) chk(snd_point_count, np, "count");
    for (int i = 0; i <= np; i++) begin
      @(negedge clk) snd_point_sel = i[3:0];
      @(negedge clk);
      chk({sounding_point_time}, i < np ? 16'(16'hfff0 - i) : 16'h0,
        "time");
      chk({sounding_point_strength}, i < np ? 16'(16'h0100 + i) : 16'h0,
        "strength");
    end
    @(negedge clk) snd_req = 1;
    @(negedge clk) snd_req = 0;
    chk(snd_status, st, "snd held");
    @(negedge clk) snd_cnf_ready = 1;
    @(negedge clk) snd_cnf_ready = 0;
    chk(snd_cnf_valid, 0, "snd drop");
    @(negedge clk);
    chk(snd_cnf_valid, 0, "snd twice");
  endtask
  task automatic cal(input logic [1:0] st, input logic [31:0] tx, rx);
    @(negedge clk) cal_req = 1;
    @(negedge clk) cal_req = 0;
    chk(cal_cnf_valid, 1, "cal valid");
    chk(cal_status, st, "cal status");
    @(negedge clk) cal_req = 1;
    @(negedge clk) cal_req = 0;
    chk(tx_path_delay_offset, tx, "tx offset");
    chk(rx_path_delay_offset, rx, "rx offset");
    @(negedge clk) cal_cnf_ready = 1;
    @(negedge clk) cal_cnf_ready = 0;
    chk(cal_cnf_valid, 0, "cal drop");
  endtask
  task automatic dps(input logic en, input logic [23:0] n);
    @(negedge clk) dps_req = 1;
    dps_enable = en;
    preamble_hold_symbols = n;
    @(negedge clk) dps_req = 0;
    chk(dps_cnf, 1, "dps cnf");
    chk(dps_active, en, "dps active");
  endtask
  // Status order: absent, host computation, no data, then success
  task automatic t_calib;
    cal(2'h3, 32'h0, 32'h0);
    phy_sounding_cap = 1;
    cal(2'h2, 32'h0, 32'h0);
    phy_self_cal_cap = 1;
    cal(2'h1, 32'h0, 32'h0);
    @(negedge clk) cal_go = 1;
    @(negedge clk) cal_go = 0;
    repeat (2) @(negedge clk);
    cal(2'h0, TXO, RXO);
  endtask
  // Host finishes calibration by sounding; third request hits busy run
  task automatic t_sounding;
    phy_sounding_cap = 0;
    snd(2'h2, -1);
    phy_sounding_cap = 1;
    snd(2'h1, -1);
    chk(starts, 1, "run started");
    snd(2'h1, -1);
    repeat (30) @(negedge clk);
    snd(2'h0, 3);
  endtask
  task automatic t_preamble;
    int n;
    dps(1'b1, 24'h000003);
    for (n = 0; n < 40 && dps_expiry_ind !== 1'b1; n++) @(negedge clk);
    chk(dps_expiry_ind, 1, "expiry");
    chk(preamble_restore, 1, "restore");
    chk(dps_active, 0, "active after expiry");
    // Three symbols of two cycles, then the notice register
    chk(n, 7, "hold length");
    for (int m = 0; m < 2; m++) begin
      dps(1'b1, 24'h000003);
      n = exps;
      if (m == 0) begin
        @(negedge clk) data_req = 1;
        @(negedge clk) data_req = 0;
      end else dps(1'b0, 24'hffffff);
      repeat (40) @(negedge clk);
      chk(exps, n, "no notice");
      chk(dps_active, 0, "active after stop");
    end
  endtask
  initial begin
    {dps_req, dps_enable, data_req, snd_req, snd_cnf_ready, cal_go} = '0;
    {cal_req, cal_cnf_ready, phy_sounding_cap, phy_self_cal_cap} = '0;
    preamble_hold_symbols = '0;
    snd_point_sel = '0;
    rst = 1;
    repeat (20) @(negedge clk);
    rst = 0;
    t_calib();
    t_sounding();
    t_preamble();
    test_done();
  end
  // Hang guard, over twenty times the expected run length
  initial begin
    #250000;
    failures++;
    test_done();
  end
endmodule // tb_top
